// ===== rtl/tocu_pkg.sv
/*
 * constants, register map and types for the timer output compare unit.
 * assumes a 32-bit axi4-lite register bus and one 200 mhz clock.
 */
// Behaviour
// R1 - compare full counter against each channel
// R2 - match sets flag next tick; irq; clear
// R3 - channel A value may set counter top
// R4 - pwm modes buffer compare, load at top/bottom
// R5 - writes hit buffer or active register
// R6 - reads return value without holding register
// R7 - high byte held; low write loads both
// R8 - force strobe acts like match, no flag
// R9 - counter write blocks next tick's matches
// R10 - software avoids writing counter to top/bottom
// R11 - output state kept across mode changes
// R12 - output select unbuffered, applies at once
// R13 - nonzero select routes state to pin
// R14 - reset clears output state to zero
// R15 - select zero leaves output state unchanged
// R16 - output select never affects capture
// R17 - software presets state before pin output
// R18 - clear-on-match clears counter at modes 4/12
// R19 - mode 0 normal; 5,6,7,14,15 fast pwm
// R20 - fixed top masks unused compare bits
// R21 - non-pwm select 1/2/3 toggles/clears/sets
// R22 - 16-bit value, buffer, flag, enable, strobe
package tocu_pkg;
	localparam int NCH = 2;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_COUNTER = 8'h04;
	localparam logic [7:0] ADDR_CAPTURE = 8'h08;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
	localparam logic [7:0] ADDR_FORCE   = 8'h10;
	localparam logic [7:0] ADDR_CMP_BASE = 8'h20;
	localparam logic [7:0] CMP_STRIDE   = 8'h10;
	localparam logic [7:0] OFS_HIGH     = 8'h00;
	localparam logic [7:0] OFS_LOW      = 8'h04;
	localparam logic [7:0] OFS_VALUE    = 8'h08;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	localparam logic [3:0] WGM_NORMAL   = 4'h0;
	localparam logic [3:0] WGM_CTC_A    = 4'h4;
	localparam logic [3:0] WGM_FAST8    = 4'h5;
	localparam logic [3:0] WGM_FAST9    = 4'h6;
	localparam logic [3:0] WGM_FAST10   = 4'h7;
	localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
	localparam logic [3:0] WGM_FAST_CAP = 4'hE;
	localparam logic [3:0] WGM_FAST_A   = 4'hF;
	localparam logic [15:0] TOP_8       = 16'h00FF;
	localparam logic [15:0] TOP_9       = 16'h01FF;
	localparam logic [15:0] TOP_10      = 16'h03FF;
	localparam logic [15:0] TOP_MAX     = 16'hFFFF;
	localparam logic [1:0] COM_OFF      = 2'h0;
	localparam logic [1:0] COM_TOGGLE   = 2'h1;
	localparam logic [1:0] COM_CLEAR    = 2'h2;
	localparam logic [1:0] COM_SET      = 2'h3;
	// control register field positions
	localparam int CTRL_WGM_LSB  = 0;
	localparam int CTRL_CS_LSB   = 4;
	localparam int CTRL_COM_LSB  = 8;
	localparam int CTRL_IEN_LSB  = 12;
	localparam int CTRL_DIR_LSB  = 16;
	localparam int CTRL_PORT_LSB = 20;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [2:0] PRESC_STOP  = 3'h0;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
	} tocu_wr_t;
	typedef struct packed {
		logic [1:0] sel;
		logic       dir;
		logic       port;
	} tocu_pin_cfg_t;
endpackage

// ===== rtl/tocu_prescale.sv
/*
 * timer clock enable divider.
 * assumes select 0 stops the timer clock entirely.
 */
`timescale 1ns/1ps
`default_nettype none
module tocu_prescale (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [2:0] sel,
	output logic            tick
);
	import tocu_pkg::*;
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;

	// count held at zero by select 0, else running; one pulse per selected period
	always_comb begin
		cnt_d = cnt_q + 10'h001;
		unique case (sel)
			3'h1: tick = 1'b1;
			3'h2: tick = (cnt_q[2:0] == 3'h7);
			3'h3: tick = (cnt_q[5:0] == 6'h3F);
			3'h4: tick = (cnt_q[7:0] == 8'hFF);
			3'h5: tick = (cnt_q == 10'h3FF);
			default: tick = 1'b0;
		endcase
		if (sel == PRESC_STOP) begin
			cnt_d = 10'h000;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= 10'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/tocu_top.sv
/*
 * output compare unit of a 16-bit timer with a minimal counter.
 * assumes an axi4-lite master and one 200 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tocu_top (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    irq_ack_a,
	input  wire logic                    irq_ack_b,
	output logic [tocu_pkg::NCH-1:0]     irq,
	output logic [tocu_pkg::NCH-1:0]     pin_out,
	output logic [tocu_pkg::NCH-1:0]     pin_oe
);
	import tocu_pkg::*;

	// bus holding state
	logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
	logic [7:0]  awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	// timer state
	logic [31:0] ctrl_q, ctrl_d;
	logic [15:0] cnt_q, cnt_d, cap_q, cap_d;
	logic [7:0]  temp_q, temp_d;
	logic        block_q, block_d;
	logic        down_q, down_d;
	logic [15:0] ocr_q [NCH], ocr_d [NCH], buf_q [NCH], buf_d [NCH]; // [R22]
	logic [NCH-1:0] flag_q, flag_d, oc_q, oc_d;
	logic [NCH-1:0] match, fire, forced;
	logic        tick;
	logic [3:0]  wgm;
	logic        pwm, fixed_top, cnt_wr;
	logic [15:0] top, fmask;
	logic        at_top, at_bot;
	logic        wr_go;
	tocu_wr_t    wr;
	logic [7:0]  rsel, wsel;
	logic [NCH-1:0] ack;

	assign ack = {irq_ack_b, irq_ack_a};
	assign wgm = ctrl_q[CTRL_WGM_LSB +: 4];

	tocu_prescale u_presc (
		.mclk (mclk),
		.rst  (rst),
		.sel  (ctrl_q[CTRL_CS_LSB +: 3]),
		.tick (tick)
	);

	// mode decode: top, pwm and fixed-top masks
	always_comb begin
		pwm = (wgm != WGM_NORMAL) && (wgm != WGM_CTC_A) && (wgm != WGM_CTC_CAP); // [R19] [R4]
		fixed_top = 1'b0;
		fmask = TOP_MAX;
		top = TOP_MAX;
		unique case (wgm)
			WGM_CTC_A, WGM_FAST_A: top = ocr_q[0]; // [R3]
			WGM_CTC_CAP, WGM_FAST_CAP: top = cap_q;
			WGM_FAST8, 4'h1: begin
				top = TOP_8;
				fmask = TOP_8;
				fixed_top = 1'b1;
			end
			WGM_FAST9, 4'h2: begin
				top = TOP_9;
				fmask = TOP_9;
				fixed_top = 1'b1;
			end
			WGM_FAST10, 4'h3: begin
				top = TOP_10;
				fmask = TOP_10;
				fixed_top = 1'b1;
			end
			4'h8, 4'hA: top = cap_q;
			4'h9, 4'hB: top = ocr_q[0];
			default: top = TOP_MAX;
		endcase
		at_top = (cnt_q == top);
		at_bot = (cnt_q == 16'h0000);
	end

	// bus write/read decode
	always_comb begin
		wr.addr = awa_q;
		wr.data = wd_q;
		wr_go = aw_q && w_q && !b_q;
		wsel = wr.addr - ADDR_CMP_BASE;
		rsel = s_axi_araddr - ADDR_CMP_BASE;
		cnt_wr = wr_go && (wr.addr == ADDR_COUNTER);
	end

	// axi4-lite handshakes; address and data taken in either order
	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		r_d = r_q;
		awa_d = awa_q;
		wd_d = wd_q;
		br_d = br_q;
		rr_d = rr_q;
		rd_d = rd_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d = 1'b1;
			wd_d = s_axi_wdata;
		end
		if (wr_go) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			br_d = RESP_OKAY;
			if (!(wr.addr inside {ADDR_CTRL, ADDR_COUNTER, ADDR_CAPTURE, ADDR_FLAGS,
					ADDR_FORCE}) && !(wr.addr >= ADDR_CMP_BASE && wsel[7:4] < 4'(NCH)
					&& wsel[3:0] != 4'hC)) begin
				br_d = RESP_SLVERR;
			end
		end
		if (b_q && s_axi_bready) begin
			b_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			r_d = 1'b1;
			rr_d = RESP_OKAY;
			rd_d = 32'h0000_0000;
			unique case (s_axi_araddr)
				ADDR_CTRL: rd_d = ctrl_q;
				ADDR_COUNTER: rd_d = {16'h0000, cnt_q};
				ADDR_CAPTURE: rd_d = {16'h0000, cap_q};
				ADDR_FLAGS: rd_d = {{(32-2*NCH){1'b0}}, oc_q, flag_q};
				ADDR_FORCE: rd_d = 32'h0000_0000;
				default: begin
					if (s_axi_araddr >= ADDR_CMP_BASE && rsel[7:4] < 4'(NCH)
							&& rsel[3:0] == OFS_VALUE[3:0]) begin
						// full value read straight, no holding register [R6] [R5]
						rd_d = {16'h0000, pwm ? buf_q[rsel[4]] : ocr_q[rsel[4]]};
					end else begin
						rr_d = RESP_SLVERR;
					end
				end
			endcase
		end
		if (r_q && s_axi_rready) begin
			r_d = 1'b0;
		end
	end

	assign s_axi_awready = !aw_q && !b_q;
	assign s_axi_wready  = !w_q && !b_q;
	assign s_axi_arready = !r_q;
	assign s_axi_bvalid  = b_q;
	assign s_axi_bresp   = br_q;
	assign s_axi_rvalid  = r_q;
	assign s_axi_rresp   = rr_q;
	assign s_axi_rdata   = rd_q;

	// counter, control, holding register and blocking
	always_comb begin
		ctrl_d = ctrl_q;
		cnt_d = cnt_q;
		cap_d = cap_q;
		temp_d = temp_q;
		down_d = 1'b0;
		block_d = block_q;
		if (tick) begin
			block_d = 1'b0;
			if ((at_top && wgm != WGM_NORMAL) || (wgm == WGM_CTC_A && match[0])) begin
				cnt_d = 16'h0000; // [R18]
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
		if (wr_go) begin
			unique case (wr.addr)
				ADDR_CTRL: ctrl_d = wr.data; // [R11] [R12]
				ADDR_COUNTER: begin
					cnt_d = wr.data[15:0];
					block_d = 1'b1; // [R9]
				end
				ADDR_CAPTURE: cap_d = wr.data[15:0];
				default: begin
					// only a real channel high byte may touch the holding register
					if (wr.addr >= ADDR_CMP_BASE && wsel[7:4] < 4'(NCH)
							&& wsel[3:0] == OFS_HIGH[3:0]) begin
						temp_d = wr.data[7:0]; // [R7]
					end
				end
			endcase
		end
	end

	// per channel compare, buffer, flag and output state
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic [1:0] com;
		logic       wlow;
		assign com = ctrl_q[CTRL_COM_LSB + 2*c +: 2];
		assign wlow = wr_go && wr.addr >= ADDR_CMP_BASE && wsel[7:4] == 4'(c)
			&& wsel[3:0] == OFS_LOW[3:0];
		assign match[c] = (cnt_q == ocr_q[c]); // [R1]
		assign fire[c] = match[c] && tick && !block_q && !cnt_wr; // [R9]
		assign forced[c] = !pwm && wr_go && wr.addr == ADDR_FORCE && wr.data[c]; // [R8]

		always_comb begin
			ocr_d[c] = ocr_q[c];
			buf_d[c] = buf_q[c];
			if (pwm && tick && (at_top || at_bot)) begin
				ocr_d[c] = buf_q[c]; // [R4]
			end
			if (wlow) begin
				// both bytes land in one cycle [R7] [R5] [R20]
				if (pwm) begin
					buf_d[c] = {temp_q, wr.data[7:0]} & (fixed_top ? fmask : TOP_MAX);
				end else begin
					ocr_d[c] = {temp_q, wr.data[7:0]} & (fixed_top ? fmask : TOP_MAX);
				end
			end
		end

		always_comb begin
			flag_d[c] = flag_q[c];
			if (ack[c] || (wr_go && wr.addr == ADDR_FLAGS && wr.data[c])) begin
				flag_d[c] = 1'b0; // [R2]
			end
			if (fire[c]) begin
				flag_d[c] = 1'b1; // set wins over clear [R2]
			end
		end

		// output state: non-pwm actions, fast pwm set/clear [R21] [R15]
		always_comb begin
			oc_d[c] = oc_q[c];
			if ((fire[c] || forced[c]) && !pwm) begin
				unique case (com)
					COM_TOGGLE: oc_d[c] = !oc_q[c];
					COM_CLEAR: oc_d[c] = 1'b0;
					COM_SET: oc_d[c] = 1'b1;
					default: oc_d[c] = oc_q[c];
				endcase
			end else if (pwm && tick && com[1]) begin
				if (at_top) begin
					oc_d[c] = !com[0];
				end else if (fire[c]) begin
					oc_d[c] = com[0];
				end
			end
		end

		always_ff @(posedge mclk) begin
			if (rst) begin
				ocr_q[c] <= 16'h0000;
				buf_q[c] <= 16'h0000;
				flag_q[c] <= 1'b0;
				oc_q[c] <= 1'b0; // [R14]
			end else begin
				ocr_q[c] <= ocr_d[c];
				buf_q[c] <= buf_d[c];
				flag_q[c] <= flag_d[c];
				oc_q[c] <= oc_d[c];
			end
		end

		// pin mux: state overrides port when select nonzero [R13] [R16]
		assign irq[c] = flag_q[c] && ctrl_q[CTRL_IEN_LSB + c]; // [R2]
		assign pin_oe[c] = ctrl_q[CTRL_DIR_LSB + c];
		assign pin_out[c] = (com != COM_OFF) ? oc_q[c] : ctrl_q[CTRL_PORT_LSB + c];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0000_0000;
			rd_q <= 32'h0000_0000;
			br_q <= RESP_OKAY;
			rr_q <= RESP_OKAY;
			ctrl_q <= CTRL_RESET;
			cnt_q <= 16'h0000;
			cap_q <= 16'h0000;
			temp_q <= 8'h00;
			block_q <= 1'b0;
			down_q <= 1'b0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			r_q <= r_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			br_q <= br_d;
			rr_q <= rr_d;
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			cap_q <= cap_d;
			temp_q <= temp_d;
			block_q <= block_d;
			down_q <= down_d;
		end
	end
endmodule
`default_nettype wire

// ===== verification/tocu_asserts.sv
/*
 * bus and pin assertions for the timer output compare unit.
 * assumes it is bound to tocu_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module tocu_asserts (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [1:0] irq,
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe
);
	import tocu_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// reset clears pins and requests
	a_reset_clears: assert property (disable iff (1'b0) rst |=> !pin_out && !pin_oe && !irq)
		else $error("outputs not cleared by reset");
	// responses stand until taken
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response changed");
	// answer timing
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	// refusal while a response is pending
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while busy");
	a_w_refused: assert property (s_axi_bvalid |-> !s_axi_wready)
		else $error("write data taken while busy");
	// direction moves only through a register write
	a_oe_by_write: assert property ($changed(pin_oe) |-> $past(s_axi_bvalid) or ##[0:2] s_axi_bvalid)
		else $error("pin direction changed without write");
	c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq[0]));
	c_pin: cover property ($changed(pin_out));
endmodule
bind tocu_top tocu_asserts chk_i (
	.mclk (mclk), .rst (rst),
	.s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
	.s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready),
	.s_axi_bvalid (s_axi_bvalid), .s_axi_bready (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready),
	.s_axi_rdata (s_axi_rdata), .s_axi_rvalid (s_axi_rvalid), .s_axi_rready (s_axi_rready),
	.irq (irq), .pin_out (pin_out), .pin_oe (pin_oe)
);
`default_nettype wire

// ===== verification/tocu_bench.sv
/*
 * self-checking bench for the timer output compare unit.
 * assumes tocu_top with its axi4-lite port and a 200 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tocu_bench;
	import tocu_pkg::*;
	logic        mclk = '0;
	logic        rst = '1;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
	logic        s_axi_bready = '1, s_axi_rready = '1, irq_ack_a = '0, irq_ack_b = '0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, irq, pin_out, pin_oe;
	int          n_mismatch = 0, n_tests = 0;

	always #2.5 mclk = ~mclk;
	tocu_top dut (
		.mclk          (mclk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.irq_ack_a     (irq_ack_a),
		.irq_ack_b     (irq_ack_b),
		.irq           (irq),
		.pin_out       (pin_out),
		.pin_oe        (pin_oe)
	);

	task automatic final_report;
		if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string n, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	// write with both beats offered together, ready sampled at negedge
	task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY);
		int t;
		logic ha, hw, hb;
		logic [1:0] r;
		t = 0;
		hb = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!hb && t < 99) begin
			@(negedge mclk);
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge mclk);
			t++;
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
		end
		// a response that never came counts as a mismatch
		chk("bvalid", 32'h1, {31'h0, hb});
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	// read and compare masked data
	task automatic rc(input logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hFFFF_FFFF,
			logic [1:0] er = RESP_OKAY);
		int t;
		logic ha, hr;
		logic [31:0] d;
		logic [1:0] r;
		t = 0;
		hr = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!hr && t < 99) begin
			@(negedge mclk);
			ha = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			t++;
			if (ha) s_axi_arvalid <= 1'b0;
		end
		chk("rvalid", 32'h1, {31'h0, hr});
		chk("rresp", {30'h0, er}, {30'h0, r});
		chk("rdata", e, d & m);
	endtask

	task automatic wait_irq;
		int t;
		t = 0;
		while (irq[0] !== 1'b1 && t < 99) begin
			@(negedge mclk);
			t++;
		end
		chk("irq", 32'h1, {31'h0, irq[0]});
		@(posedge mclk);
	endtask

	task automatic t_reset;
		rc(ADDR_CTRL, 32'h0);
		rc(ADDR_FLAGS, 32'h0);
		chk("pin_out", 32'h0, {30'h0, pin_out});
		wr(8'hFC, 32'h1, RESP_SLVERR);
		rc(8'hFC, 32'h0, 32'h0, RESP_SLVERR);
	endtask

	task automatic t_value;
		wr(8'h20, 32'h12);
		wr(8'h24, 32'h34);
		rc(8'h28, 32'h1234);
		wr(8'h30, 32'hAB);
		rc(8'h38, 32'h0);
		wr(8'h34, 32'hCD);
		rc(8'h38, 32'hABCD);
	endtask

	// forced matches under each output select, then a mode change
	task automatic t_force;
		logic [1:0] sel [6] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h3, 2'h0};
		logic       st [6] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
		// preset the state while the pin is still an input
		wr(ADDR_CTRL, 32'h0000_0200);
		wr(ADDR_FORCE, 32'h1);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_CTRL, 32'h0001_0000 | {22'h0, sel[i], 8'h00});
			wr(ADDR_FORCE, 32'h1);
			rc(ADDR_FLAGS, {29'h0, st[i], 2'h0}, 32'h5);
			chk("pin_out", {31'h0, st[i] & (sel[i] != 2'h0)}, {31'h0, pin_out[0]});
			chk("pin_oe", 32'h1, {31'h0, pin_oe[0]});
		end
		wr(ADDR_CTRL, 32'h0001_0005);
		rc(ADDR_FLAGS, 32'h4, 32'h4);
		wr(8'h30, 32'h12);
		wr(8'h34, 32'h34);
		rc(8'h38, 32'h34);
	endtask

	// real matches, software clear and interrupt acknowledge
	task automatic t_match;
		wr(ADDR_CTRL, 32'h0);
		wr(8'h20, 32'h0);
		wr(8'h24, 32'h5);
		wr(ADDR_COUNTER, 32'h0);
		wr(ADDR_CTRL, 32'h1110);
		wait_irq();
		wr(ADDR_CTRL, 32'h1100);
		rc(ADDR_FLAGS, 32'h1, 32'h5);
		wr(ADDR_FLAGS, 32'h1);
		rc(ADDR_FLAGS, 32'h0, 32'h1);
		chk("irq", 32'h0, {31'h0, irq[0]});
		wr(ADDR_COUNTER, 32'h4);
		wr(ADDR_CTRL, 32'h1110);
		wait_irq();
		wr(ADDR_CTRL, 32'h1100);
		irq_ack_a <= 1'b1;
		@(posedge mclk);
		irq_ack_a <= 1'b0;
		rc(ADDR_FLAGS, 32'h0, 32'h1);
		chk("irq", 32'h0, {31'h0, irq[0]});
	endtask

	// counter write masks a match; disabled request stays low
	task automatic t_block;
		wr(ADDR_COUNTER, 32'h5);
		wr(ADDR_CTRL, 32'h1110);
		repeat (20) @(posedge mclk);
		wr(ADDR_CTRL, 32'h1100);
		rc(ADDR_FLAGS, 32'h0, 32'h1);
		wr(ADDR_COUNTER, 32'h4);
		wr(ADDR_CTRL, 32'h0110);
		repeat (20) @(posedge mclk);
		chk("irq", 32'h0, {31'h0, irq[0]});
		rc(ADDR_FLAGS, 32'h1, 32'h1);
	endtask

	// clear-on-match wraps at channel a; pwm buffer loads at bottom
	task automatic t_pwm;
		wr(ADDR_CTRL, 32'h0);
		wr(8'h20, 32'h0);
		wr(8'h24, 32'h3);
		wr(ADDR_COUNTER, 32'h0);
		wr(ADDR_CTRL, {24'h0, 4'h1, WGM_CTC_A});
		repeat (20) @(posedge mclk);
		wr(ADDR_CTRL, {28'h0, WGM_CTC_A});
		rc(ADDR_COUNTER, 32'h0, 32'hFFFF_FFFC);
		wr(ADDR_CTRL, {28'h0, WGM_FAST8});
		wr(8'h30, 32'h0);
		wr(8'h34, 32'h10);
		wr(ADDR_CTRL, 32'h0);
		rc(8'h38, 32'hABCD);
		wr(ADDR_COUNTER, 32'h0);
		wr(ADDR_CTRL, {24'h0, 4'h1, WGM_FAST8});
		repeat (20) @(posedge mclk);
		wr(ADDR_CTRL, 32'h0);
		rc(8'h38, 32'h10);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_value();
		t_force();
		t_match();
		t_block();
		t_pwm();
		final_report();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		final_report();
	end
endmodule
`default_nettype wire
